// file: design/sense_pkg.sv
// Shared constants, register map and parameter-set layout of the reading-rate controller.
package sense_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Timing.
	localparam int unsigned CLK_HZ   = 50_000_000;           // pclk rate in Hz
	localparam int unsigned BASE_MS  = 50;                   // timebase unit in ms
	localparam int unsigned BASE_CYC = CLK_HZ / 1000 * BASE_MS;
	localparam int unsigned SEC_MS   = 1000;                 // rate form counts per second
	localparam int unsigned SEC_CYC  = CLK_HZ / 1000 * SEC_MS;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets; image offsets add NV_BASE.
	localparam logic [11:0] A_CMD      = 12'h000;
	localparam logic [11:0] A_INTEG    = 12'h004;
	localparam logic [11:0] A_SHIFT    = 12'h008;
	localparam logic [11:0] A_IDLE     = 12'h00c;
	localparam logic [11:0] A_SKIP     = 12'h010;
	localparam logic [11:0] A_OPMODE   = 12'h014;
	localparam logic [11:0] A_DEADBAND = 12'h018;
	localparam logic [11:0] A_DEST     = 12'h01c;
	localparam logic [11:0] A_SLOPE    = 12'h020;
	localparam logic [11:0] A_OFFSET   = 12'h024;
	localparam logic [11:0] A_SPAN     = 12'h028;
	localparam logic [11:0] A_HOSTDAC  = 12'h02c;
	localparam logic [11:0] A_ADDR     = 12'h030;
	localparam logic [11:0] A_READING  = 12'h034;
	localparam logic [11:0] A_STATUS   = 12'h038;
	localparam logic [11:0] NV_BASE    = 12'h080;

	// Command codes written to the command register.
	localparam logic [1:0] CMD_OFF    = 2'h0;
	localparam logic [1:0] CMD_PERMIT = 2'h1;
	localparam logic [1:0] CMD_SINGLE = 2'h2;
	localparam logic [1:0] CMD_STORE  = 2'h3;

	// Destination codes.
	localparam logic [1:0] DEST_ANALOG  = 2'h0;
	localparam logic [1:0] DEST_BOTH    = 2'h1;
	localparam logic [1:0] DEST_DIGITAL = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Limits and arithmetic scaling.
	localparam logic [6:0] INT_N_MIN  = 7'h01;
	localparam logic [6:0] INT_N_MAX  = 7'h78;               // 120
	localparam logic [3:0] SKIP_MAX   = 4'ha;                // 10
	localparam logic [7:0] SKIP_UNIT  = 8'h64;               // 100 readings per step
	localparam logic [5:0] DB_DD_MAX  = 6'h3c;               // 60
	localparam logic [7:0] MB_MAX     = 8'h78;               // slope/offset magnitude 120
	localparam logic [6:0] PCT_MAX    = 7'h64;               // 100 percent
	localparam logic signed [47:0] FS_CODE = 48'sh7fff;      // full-scale reading code
	localparam logic signed [47:0] UNIT_K  = 48'sh68e;       // 0.005 % as K / 2**UNIT_SH
	localparam int unsigned        UNIT_SH = 25;
	localparam logic [31:0] DAC_FULL = 32'hfff;              // 12-bit converter top code
	localparam logic [31:0] PCT_K    = 32'h51f;              // 1/100 as K / 2**PCT_SH
	localparam int unsigned PCT_SH   = 17;

	////////////////////////////////////////////////////////////////////////////////
	// One complete parameter set, held both in working and in retained storage.
	typedef struct packed {
		logic               rate_form;
		logic [6:0]         integ_n;
		logic [3:0]         dbl_thr;
		logic [3:0]         fast_thr;
		logic [7:0]         idle_cnt;
		logic [3:0]         skip_r;
		logic               change_only;
		logic               checksum;
		logic               extended;
		logic               watchdog;
		logic [5:0]         db_dd;
		logic [1:0]         db_n;
		logic [1:0]         dest;
		logic signed [7:0]  slope_m;
		logic signed [7:0]  offset_b;
		logic [6:0]         span_lo;
		logic [6:0]         span_hi;
		logic [11:0]        host_dac;
		logic               host_dac_sel;
	} params_t;

	localparam params_t PARAMS_DEF = '{
		rate_form: 1'b0, integ_n: 7'h02, dbl_thr: 4'h0, fast_thr: 4'h0,
		idle_cnt: 8'h00, skip_r: 4'h0, change_only: 1'b0, checksum: 1'b0,
		extended: 1'b1, watchdog: 1'b0, db_dd: 6'h00, db_n: 2'h0,
		dest: DEST_BOTH, slope_m: 8'sh00, offset_b: 8'sh00, span_lo: 7'h00,
		span_hi: 7'h64, host_dac: 12'h000, host_dac_sel: 1'b0};

	// Format flags driven to the serial reply formatter.
	typedef struct packed {
		logic       checksum;
		logic       extended;
		logic       watchdog;
		logic [7:0] reply_addr;
		logic       reply_null;
	} fmt_t;

endpackage

// file: design/reading_rate_ctrl.sv
// Reading acquisition timing, filtering, output gating and parameter storage behind APB.
//
// Function
// - Parameter writes need a prior permit or single permit; reads never do.
// - Every writable parameter reads back at its own offset.
// - Writes change working copy at once; store command copies it to retained image.
// - Destination, slope, offset and span writes also update the retained image directly.
// - Rate form gives n readings per second, n from 1 to 120.
// - Period form gives n times 100 ms per reading.
// - After reset the setting is period form with n equal to 2.
// - Speed shifting acts only in period form.
// - Change at or over threshold doubles rate or gives 50 ms updates.
// - Threshold s means s times 0.01 % full scale; zero disables.
// - Idle count c inserts c idle integration periods between samples.
// - Skip value r suppresses identical readings until r times 100 skipped.
// - Output every reading or only changed readings; default every.
// - Checksum flag selects appended checksum for binary replies.
// - Extended flag selects extended reply format.
// - Watchdog flag enables the watchdog.
// - Deadband equals dd times 2 to the power n times 0.005 % full scale.
// - Reported reading holds while samples stay inside the deadband.
// - Destination selects analog, both or digital output.
// - A 12-bit converter code carries compensated or host value.
// - Each reading is corrected as slope times reading plus offset.
// - Analog span lies inside full range in one percent steps.
// - Replies carry the assigned address, or the null prefix when unassigned.
module reading_rate_ctrl #(
	parameter int unsigned BASE_CYC = sense_pkg::BASE_CYC,
	parameter int unsigned SEC_CYC  = sense_pkg::SEC_CYC
) (
	// Clock and reset.
	input  wire logic                pclk,
	input  wire logic                presetn,
	// APB slave.
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Converter result, sampled at the close of each integration.
	input  wire logic signed [15:0]  pressure_in,
	output logic                     sample_take,
	// Digital reading stream and reply format.
	output logic                     rdg_valid,
	output logic signed [15:0]       rdg_value,
	output sense_pkg::fmt_t          fmt,
	// Analog converter load.
	output logic      [11:0]         dac_value,
	output logic                     dac_load
);

	localparam int TW = $clog2(BASE_CYC + 1);
	localparam int SW = $clog2(SEC_CYC + 1) + 1;

	typedef enum logic [0:0] {PH_INTEG, PH_IDLE} phase_t;
	typedef enum logic [1:0] {SH_NONE, SH_DOUBLE, SH_FAST} shift_t;

	typedef struct packed {
		sense_pkg::params_t ram;
		sense_pkg::params_t nv;
		logic               perm_cont;
		logic               perm_single;
		logic [7:0]         addr;
		logic               addr_set;
		logic               pready;
		logic [31:0]        prdata;
		logic               pslverr;
		phase_t             phase;
		shift_t             shift;
		logic [TW-1:0]      tick_cnt;
		logic [8:0]         per_cnt;
		logic [SW-1:0]      acc;
		logic [7:0]         idle_left;
		logic signed [15:0] prev;
		logic signed [15:0] reported;
		logic [9:0]         skip_cnt;
		logic               sample_take;
		logic               rdg_valid;
		logic signed [15:0] rdg_value;
		sense_pkg::fmt_t    fmt;
		logic [11:0]        dac_value;
		logic               dac_load;
	} state_t;

	state_t q;
	state_t d;

	////////////////////////////////////////////////////////////////////////////////
	// Parameter read-back word for an offset; zero for anything else.
	function automatic logic [31:0] param_word(sense_pkg::params_t p, logic [11:0] a);
		logic [31:0] w;
		w = 32'h0;
		case (a)
			sense_pkg::A_INTEG:    w = {23'h0, p.rate_form, 1'b0, p.integ_n};
			sense_pkg::A_SHIFT:    w = {24'h0, p.fast_thr, p.dbl_thr};
			sense_pkg::A_IDLE:     w = {24'h0, p.idle_cnt};
			sense_pkg::A_SKIP:     w = {28'h0, p.skip_r};
			sense_pkg::A_OPMODE:   w = {28'h0, p.watchdog, p.extended, p.checksum, p.change_only};
			sense_pkg::A_DEADBAND: w = {22'h0, p.db_n, 2'h0, p.db_dd};
			sense_pkg::A_DEST:     w = {30'h0, p.dest};
			sense_pkg::A_SLOPE:    w = {{24{p.slope_m[7]}}, p.slope_m};
			sense_pkg::A_OFFSET:   w = {{24{p.offset_b[7]}}, p.offset_b};
			sense_pkg::A_SPAN:     w = {17'h0, p.span_hi, 1'b0, p.span_lo};
			sense_pkg::A_HOSTDAC:  w = {15'h0, p.host_dac_sel, 4'h0, p.host_dac};
			default:               w = 32'h0;
		endcase
		return w;
	endfunction

	// Range check of a parameter write; out-of-range values are refused whole.
	function automatic logic param_ok(logic [11:0] a, logic [31:0] w);
		logic ok;
		logic [7:0] mag;
		ok = 1'b1;
		mag = w[7] ? 8'(-w[7:0]) : w[7:0];
		case (a)
			sense_pkg::A_INTEG:    ok = w[6:0] >= sense_pkg::INT_N_MIN && w[6:0] <= sense_pkg::INT_N_MAX;
			sense_pkg::A_SKIP:     ok = w[3:0] <= sense_pkg::SKIP_MAX;
			sense_pkg::A_DEADBAND: ok = w[5:0] <= sense_pkg::DB_DD_MAX;
			sense_pkg::A_DEST:     ok = w[1:0] != 2'h3;
			sense_pkg::A_SLOPE,
			sense_pkg::A_OFFSET:   ok = mag <= sense_pkg::MB_MAX;
			sense_pkg::A_SPAN:     ok = w[14:8] <= sense_pkg::PCT_MAX && w[6:0] <= w[14:8];
			default:               ok = 1'b1;
		endcase
		return ok;
	endfunction

	// Apply one parameter write to a parameter set.
	function automatic sense_pkg::params_t param_write(sense_pkg::params_t p, logic [11:0] a,
			logic [31:0] w);
		sense_pkg::params_t n;
		n = p;
		case (a)
			sense_pkg::A_INTEG: begin
				n.rate_form = w[8];
				n.integ_n   = w[6:0];
			end
			sense_pkg::A_SHIFT: begin
				n.dbl_thr  = w[3:0];
				n.fast_thr = w[7:4];
			end
			sense_pkg::A_IDLE:     n.idle_cnt = w[7:0];
			sense_pkg::A_SKIP:     n.skip_r = w[3:0];
			sense_pkg::A_OPMODE: begin
				n.change_only = w[0];
				n.checksum    = w[1];
				n.extended    = w[2];
				n.watchdog    = w[3];
			end
			sense_pkg::A_DEADBAND: begin
				n.db_dd = w[5:0];
				n.db_n  = w[9:8];
			end
			sense_pkg::A_DEST:     n.dest = w[1:0];
			sense_pkg::A_SLOPE:    n.slope_m = w[7:0];
			sense_pkg::A_OFFSET:   n.offset_b = w[7:0];
			sense_pkg::A_SPAN: begin
				n.span_lo = w[6:0];
				n.span_hi = w[14:8];
			end
			sense_pkg::A_HOSTDAC: begin
				n.host_dac     = w[11:0];
				n.host_dac_sel = w[16];
			end
			default: n = p;
		endcase
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Reading arithmetic: compensation, thresholds, deadband and converter scaling.
	logic signed [47:0] p_w;
	logic signed [47:0] slope_t;
	logic signed [47:0] offs_t;
	logic signed [47:0] comp_w;
	logic signed [15:0] comp;
	logic signed [47:0] dlt_w;
	logic signed [47:0] rep_w;
	logic signed [47:0] thr_dbl;
	logic signed [47:0] thr_fast;
	logic signed [47:0] db_w;
	logic        [31:0] c_pos;
	logic        [31:0] lo_code;
	logic        [31:0] span_code;
	logic        [31:0] dac_w;

	// Scaling in 0.005 % steps keeps one multiplier constant for all five terms.
	assign p_w     = 48'(pressure_in);
	assign slope_t = (p_w * 48'(q.ram.slope_m) * sense_pkg::UNIT_K) >>> sense_pkg::UNIT_SH;
	assign offs_t  = (48'(q.ram.offset_b) * sense_pkg::FS_CODE * sense_pkg::UNIT_K)
			>>> sense_pkg::UNIT_SH;
	assign comp_w  = p_w + slope_t + offs_t;
	assign comp    = comp_w > 48'sh7fff ? 16'sh7fff :
			comp_w < -48'sh8000 ? -16'sh8000 : comp_w[15:0];
	assign dlt_w   = (48'(comp) >= 48'(q.prev)) ? 48'(comp) - 48'(q.prev) : 48'(q.prev) - 48'(comp);
	assign rep_w   = (48'(comp) >= 48'(q.reported)) ? 48'(comp) - 48'(q.reported) :
			48'(q.reported) - 48'(comp);
	assign thr_dbl  = (48'(q.ram.dbl_thr) * 48'sh2 * sense_pkg::FS_CODE * sense_pkg::UNIT_K)
			>>> sense_pkg::UNIT_SH;
	assign thr_fast = (48'(q.ram.fast_thr) * 48'sh2 * sense_pkg::FS_CODE * sense_pkg::UNIT_K)
			>>> sense_pkg::UNIT_SH;
	assign db_w     = ((48'(q.ram.db_dd) <<< q.ram.db_n) * sense_pkg::FS_CODE * sense_pkg::UNIT_K)
			>>> sense_pkg::UNIT_SH;
	assign c_pos     = comp[15] ? 32'h0 : 32'(comp);
	assign lo_code   = (32'(q.ram.span_lo) * sense_pkg::DAC_FULL * sense_pkg::PCT_K)
			>> sense_pkg::PCT_SH;
	assign span_code = (32'(q.ram.span_hi - q.ram.span_lo) * sense_pkg::DAC_FULL * sense_pkg::PCT_K)
			>> sense_pkg::PCT_SH;
	assign dac_w     = lo_code + ((c_pos * span_code) >> 15);

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic for the bus slave, storage and acquisition sequencer.
	logic          setup;
	logic          commit;
	logic          permit;
	logic          is_param;
	logic [11:0]   poff;
	logic          tick;
	logic [8:0]    target;
	logic [SW-1:0] acc_nx;
	logic          per_end;
	logic          changed;
	logic          emit;
	logic [9:0]    skip_lim;

	always_comb begin
		d = q;
		setup    = psel && !penable;
		commit   = psel && penable && q.pready && pwrite && !q.pslverr;
		permit   = q.perm_cont || q.perm_single;
		poff     = paddr & ~sense_pkg::NV_BASE;
		is_param = poff >= sense_pkg::A_INTEG && poff <= sense_pkg::A_HOSTDAC && paddr[1:0] == 2'h0;
		tick     = 1'b0;
		target   = 9'h0;
		acc_nx   = '0;
		per_end  = 1'b0;
		changed  = 1'b0;
		emit     = 1'b0;
		skip_lim = 10'h0;
		d.pready      = 1'b0;
		d.pslverr     = 1'b0;
		d.sample_take = 1'b0;
		d.rdg_valid   = 1'b0;
		d.dac_load    = 1'b0;

		// Answer in the cycle after setup, so every access has one ready cycle.
		if (setup) begin
			d.pready  = 1'b1;
			d.prdata  = 32'h0;
			if (is_param && paddr[7]) begin
				d.prdata  = param_word(q.nv, poff);
				d.pslverr = pwrite;
			end else if (is_param) begin
				d.prdata  = param_word(q.ram, paddr);
				d.pslverr = pwrite && (!permit || !param_ok(paddr, pwdata));
			end else begin
				case (paddr)
					sense_pkg::A_CMD:     d.prdata = {30'h0, q.perm_single, q.perm_cont};
					sense_pkg::A_ADDR: begin
						d.prdata  = {23'h0, q.addr_set, q.addr};
						d.pslverr = pwrite && !permit;
					end
					sense_pkg::A_READING: begin
						d.prdata  = {{16{q.reported[15]}}, q.reported};
						d.pslverr = pwrite;
					end
					sense_pkg::A_STATUS: begin
						d.prdata  = {28'h0, q.shift, q.phase == PH_IDLE, q.ram.rate_form};
						d.pslverr = pwrite;
					end
					default: d.pslverr = 1'b1;
				endcase
				if (paddr == sense_pkg::A_CMD && pwrite && pwdata[1:0] == sense_pkg::CMD_STORE)
					d.pslverr = !permit;
			end
		end

		// Committed writes; a single permit is spent by the one write it allows.
		if (commit) begin
			if (is_param) begin
				d.ram = param_write(q.ram, paddr, pwdata);
				d.perm_single = 1'b0;
				if (paddr == sense_pkg::A_DEST || paddr == sense_pkg::A_SLOPE ||
						paddr == sense_pkg::A_OFFSET || paddr == sense_pkg::A_SPAN)
					d.nv = param_write(q.nv, paddr, pwdata);
				if (paddr == sense_pkg::A_HOSTDAC && pwdata[16] && q.ram.dest != sense_pkg::DEST_DIGITAL) begin
					d.dac_value = pwdata[11:0];
					d.dac_load  = 1'b1;
				end
			end else if (paddr == sense_pkg::A_ADDR) begin
				d.addr        = pwdata[7:0];
				d.addr_set    = pwdata[8];
				d.perm_single = 1'b0;
			end else if (paddr == sense_pkg::A_CMD) begin
				case (pwdata[1:0])
					sense_pkg::CMD_OFF:    {d.perm_cont, d.perm_single} = 2'b00;
					sense_pkg::CMD_PERMIT: d.perm_cont = 1'b1;
					sense_pkg::CMD_SINGLE: d.perm_single = 1'b1;
					sense_pkg::CMD_STORE: begin
						d.nv          = q.ram;
						d.perm_single = 1'b0;
					end
					default: d.perm_single = q.perm_single;
				endcase
			end
		end

		// Common 50 ms timebase tick.
		if (q.tick_cnt >= TW'(BASE_CYC - 1)) begin
			d.tick_cnt = '0;
			tick       = 1'b1;
		end else begin
			d.tick_cnt = q.tick_cnt + 1'b1;
		end

		// Period length: rate form by a fractional accumulator, period form in ticks.
		if (q.ram.rate_form) begin
			acc_nx = q.acc + SW'(q.ram.integ_n);
			if (acc_nx >= SW'(SEC_CYC)) begin
				d.acc   = acc_nx - SW'(SEC_CYC);
				per_end = 1'b1;
			end else begin
				d.acc = acc_nx;
			end
			d.per_cnt = 9'h0;
		end else begin
			case (q.shift)
				SH_FAST:   target = 9'h1;
				SH_DOUBLE: target = {2'h0, q.ram.integ_n};
				default:   target = {1'b0, q.ram.integ_n, 1'b0};
			endcase
			if (tick) begin
				if (q.per_cnt + 1'b1 >= target) begin
					d.per_cnt = 9'h0;
					per_end   = 1'b1;
				end else begin
					d.per_cnt = q.per_cnt + 1'b1;
				end
			end
		end

		// Sequencer: one integration, then the programmed idle periods.
		case (q.phase)
			PH_INTEG: begin
				if (per_end) begin
					d.sample_take = 1'b1;
					d.prev        = comp;
					if (q.ram.idle_cnt != 8'h0) begin
						d.phase     = PH_IDLE;
						d.idle_left = q.ram.idle_cnt;
					end
					// Speed shift decision for the next period; rate form never shifts.
					d.shift = SH_NONE;
					if (!q.ram.rate_form) begin
						if (q.ram.fast_thr != 4'h0 && dlt_w >= thr_fast)
							d.shift = SH_FAST;
						else if (q.ram.dbl_thr != 4'h0 && dlt_w >= thr_dbl)
							d.shift = SH_DOUBLE;
					end
					// Deadband filter on the reported value.
					changed = rep_w > db_w;
					if (changed) begin
						d.reported = comp;
						d.skip_cnt = 10'h0;
					end
					skip_lim = 10'(q.ram.skip_r) * 10'(sense_pkg::SKIP_UNIT);
					if (q.ram.skip_r != 4'h0) begin
						if (!changed && q.skip_cnt + 1'b1 >= skip_lim) begin
							d.skip_cnt = 10'h0;
							emit       = 1'b1;
						end else if (!changed) begin
							d.skip_cnt = q.skip_cnt + 1'b1;
						end
						emit = emit || changed;
					end else begin
						emit = changed || !q.ram.change_only;
					end
					if (emit && q.ram.dest != sense_pkg::DEST_ANALOG) begin
						d.rdg_valid = 1'b1;
						d.rdg_value = changed ? comp : q.reported;
					end
					if (q.ram.dest != sense_pkg::DEST_DIGITAL) begin
						d.dac_load  = 1'b1;
						d.dac_value = d.ram.host_dac_sel ? d.ram.host_dac :
								(dac_w > sense_pkg::DAC_FULL ? 12'hfff : dac_w[11:0]);
					end
				end
			end
			PH_IDLE: begin
				if (per_end) begin
					d.idle_left = q.idle_left - 1'b1;
					if (q.idle_left == 8'h1)
						d.phase = PH_INTEG;
				end
			end
			default: d.phase = PH_INTEG;
		endcase

		// Reply format flags follow the working parameters; reply address and null prefix follow the address register.
		d.fmt.checksum   = q.ram.checksum;
		d.fmt.extended   = q.ram.extended;
		d.fmt.watchdog   = q.ram.watchdog;
		d.fmt.reply_addr = q.addr_set ? q.addr : 8'h01;
		d.fmt.reply_null = !q.addr_set;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register; reset loads the factory parameter set into both copies.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q             <= '0;
			q.ram         <= sense_pkg::PARAMS_DEF;
			q.nv          <= sense_pkg::PARAMS_DEF;
			q.phase       <= PH_INTEG;
			q.shift       <= SH_NONE;
			q.fmt.extended   <= 1'b1;
			q.fmt.reply_addr <= 8'h01;
			q.fmt.reply_null <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Outputs come straight from the state register.
	assign prdata      = q.prdata;
	assign pready      = q.pready;
	assign pslverr     = q.pslverr;
	assign sample_take = q.sample_take;
	assign rdg_valid   = q.rdg_valid;
	assign rdg_value   = q.rdg_value;
	assign fmt         = q.fmt;
	assign dac_value   = q.dac_value;
	assign dac_load    = q.dac_load;

endmodule // reading_rate_ctrl

// file: testbench/reading_rate_ctrl_checker.sv
// Port-level assertions for the reading-rate controller.
module reading_rate_ctrl_checker #(
	parameter int unsigned BASE_CYC = 20,
	parameter int unsigned SEC_CYC  = 400
) (
	// Clock and reset.
	input wire logic               pclk,
	input wire logic               presetn,
	// APB.
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic               pready,
	input wire logic               pslverr,
	// Acquisition and outputs.
	input wire logic               sample_take,
	input wire logic               rdg_valid,
	input wire logic signed [15:0] rdg_value,
	input wire logic [11:0]        dac_value,
	input wire logic               dac_load,
	input wire sense_pkg::fmt_t    fmt
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////////////////
	// Cycles since the last sample; saturates so long idle runs cannot wrap.
	logic [15:0] gap_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) gap_q <= 16'h0000;
		else gap_q <= sample_take ? 16'h0001 : gap_q + {15'h0000, ~&gap_q};
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////////////
	// A setup cycle is answered in the next cycle, and the answer lasts one cycle.
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence answer_s;
		pready ##1 !pready;
	endsequence
	ready_next_a: assert property (setup_s |=> answer_s)
		else $error("pready not one cycle after setup");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr outside an answer");
	take_pulse_a: assert property (sample_take |=> !sample_take)
		else $error("sample_take longer than one cycle");
	emit_take_a: assert property (rdg_valid |-> sample_take)
		else $error("reading emitted without a sample");
	value_held_a: assert property ($changed(rdg_value) |-> rdg_valid)
		else $error("reported value moved without emission");
	dac_held_a: assert property ($changed(dac_value) |-> dac_load)
		else $error("dac_value moved without a load");
	min_gap_a: assert property (sample_take |-> gap_q >= SEC_CYC / 120)
		else $error("samples closer than the fastest rate");
	fmt_write_a: assert property ($changed(fmt) |-> $past(psel && penable && pwrite, 2))
		else $error("format flags moved without a write");
	null_addr_a: assert property (fmt.reply_null |-> fmt.reply_addr == 8'h01)
		else $error("null prefix with a wrong address");
endmodule // reading_rate_ctrl_checker

bind reading_rate_ctrl reading_rate_ctrl_checker #(.BASE_CYC(BASE_CYC), .SEC_CYC(SEC_CYC)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pready(pready), .pslverr(pslverr), .sample_take(sample_take), .rdg_valid(rdg_valid),
	.rdg_value(rdg_value), .dac_value(dac_value), .dac_load(dac_load), .fmt(fmt));

// file: testbench/pressure_source.sv
// Behavioural pressure converter feeding the controller's sample input.
module pressure_source (
	// Clock and reset.
	input  wire logic          pclk,
	input  wire logic          presetn,
	// Sample handshake and drive mode.
	input  wire logic          sample_take,
	input  wire logic          steady,
	// Converter result.
	output logic signed [15:0] pressure_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Unless steady, step between two far levels after each sample so every threshold is crossed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) pressure_in <= 16'sh0100;
		else if (sample_take && !steady) pressure_in <= (pressure_in == 16'sh0100) ? 16'sh4000 : 16'sh0100;
	end
endmodule // pressure_source

// file: testbench/tb_reading_rate_ctrl.sv
// Self-checking bench for the reading-rate controller.
module tb_reading_rate_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic               presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, steady = 1'b0;
	logic               pclk, pready, pslverr, er, sample_take, rdg_valid, dac_load;
	logic [11:0]        paddr = 12'h000, dac_value;
	logic [31:0]        pwdata = 32'h0, prdata, rd;
	logic signed [15:0] pressure_in, rdg_value;
	sense_pkg::fmt_t    fmt;
	int                 bad_count = 0, checks_done = 0, cyc = 0, ns, nv, nd;
	logic [11:0]        ra [8] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c, 12'h084};
	logic [31:0]        rv [8] = '{32'h2, 32'h0, 32'h0, 32'h0, 32'h4, 32'h0, 32'h1, 32'h2};
	// Short timebase keeps each period a few tens of cycles.
	reading_rate_ctrl #(.BASE_CYC(20), .SEC_CYC(400)) u_reading_rate_ctrl (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pressure_in(pressure_in), .sample_take(sample_take), .rdg_valid(rdg_valid),
		.rdg_value(rdg_value), .fmt(fmt), .dac_value(dac_value), .dac_load(dac_load));
	pressure_source u_pressure_source (.pclk(pclk), .presetn(presetn),
		.sample_take(sample_take), .steady(steady), .pressure_in(pressure_in));
	////////////////////////////////////////////////////////////////////////////////
	// Clock, pulse tallies taken mid-cycle, and the hang limit.
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(negedge pclk) begin
		ns += sample_take;
		nv += rdg_valid;
		nd += dac_load;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task wrap_up();
		if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		checks_done++;
		if (g !== x) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, g);
		end
	endtask
	// One APB transfer; the answer is taken at the rising edge that sees pready.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int t;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 100);
		chk("pready", 32'h1, {31'h0, pready});
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		chk("pslverr", {31'h0, e}, {31'h0, er});
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk("prdata", x, rd);
	endtask
	// Syncs to one sample, then counts cycles to the next.
	task gap(input logic [31:0] x);
		int n;
		repeat (2) begin
			n = 0;
			do begin
				@(negedge pclk);
				n++;
			end while (sample_take !== 1'b1 && n < 9000);
		end
		chk("gap", x, n);
	endtask
	task win(input logic ev, input logic ed);
		@(posedge pclk);
		ns = 0;
		nv = 0;
		nd = 0;
		repeat (300) @(posedge pclk);
		chk("emits", ev ? ns : 0, nv);
		chk("loads", ed ? ns : 0, nd);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) rdc(ra[i], rv[i]);
		chk("addr", 32'h101, {23'h0, fmt.reply_null, fmt.reply_addr});
		apb(1'b0, 12'h03c, 32'h0);
		chk("unmapped", 32'h1, {31'h0, er});
		wr(12'h004, 32'h5, 1'b1);
		rdc(12'h004, 32'h2);
		wr(12'h000, 32'h1, 1'b0);
		wr(12'h004, 32'h0, 1'b1);
		wr(12'h004, 32'h79, 1'b1);
		wr(12'h004, 32'h178, 1'b0);
		rdc(12'h004, 32'h178);
		wr(12'h008, 32'h10, 1'b0);
		wr(12'h004, 32'h10a, 1'b0);
		gap(32'd40);
		wr(12'h004, 32'h2, 1'b0);
		gap(32'd20);
		wr(12'h008, 32'h1, 1'b0);
		gap(32'd40);
		wr(12'h008, 32'h0, 1'b0);
		gap(32'd80);
		wr(12'h00c, 32'h1, 1'b0);
		gap(32'd160);
		wr(12'h00c, 32'h0, 1'b0);
		wr(12'h004, 32'h3, 1'b0);
		rdc(12'h084, 32'h2);
		wr(12'h000, 32'h3, 1'b0);
		rdc(12'h084, 32'h3);
		gap(32'd120);
		wr(12'h01c, 32'h2, 1'b0);
		rdc(12'h09c, 32'h2);
		win(1'b1, 1'b0);
		wr(12'h01c, 32'h0, 1'b0);
		win(1'b0, 1'b1);
		wr(12'h01c, 32'h1, 1'b0);
		wr(12'h014, 32'h1, 1'b0);
		steady <= 1'b1;
		gap(32'd120);
		win(1'b0, 1'b1);
		steady <= 1'b0;
		gap(32'd120);
		win(1'b1, 1'b1);
		wr(12'h000, 32'h0, 1'b0);
		wr(12'h000, 32'h2, 1'b0);
		wr(12'h010, 32'ha, 1'b0);
		wr(12'h010, 32'h3, 1'b1);
		rdc(12'h010, 32'ha);
		wr(12'h000, 32'h1, 1'b0);
		wr(12'h010, 32'hb, 1'b1);
		wr(12'h018, 32'h33d, 1'b1);
		wr(12'h018, 32'h33c, 1'b0);
		wr(12'h014, 32'ha, 1'b0);
		repeat (2) @(negedge pclk);
		chk("fmt", 32'h5, {29'h0, fmt.checksum, fmt.extended, fmt.watchdog});
		wr(12'h030, 32'h12a, 1'b0);
		repeat (2) @(negedge pclk);
		chk("addr", 32'h2a, {23'h0, fmt.reply_null, fmt.reply_addr});
		wr(12'h02c, 32'h10abc, 1'b0);
		repeat (2) @(negedge pclk);
		chk("dac", 32'habc, {20'h0, dac_value});
		wr(12'h034, 32'h0, 1'b1);
		wrap_up();
	end
endmodule // tb_reading_rate_ctrl
